// ### rtl/sdwb_pkg.sv
// Constants and carrier types for the write burst block
package sdwb_pkg;
  // Register offsets
  localparam logic [7:0] REG_MODE0 = 8'h00;
  localparam logic [7:0] REG_LAT   = 8'h04;
  localparam logic [7:0] REG_CTRL  = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_PEEKA = 8'h14;
  localparam logic [7:0] REG_PEEKD = 8'h18;
  // Burst length encodings of mode register zero bits 1:0
  localparam logic [1:0] MR0_BL8 = 2'h0;
  localparam logic [1:0] MR0_OTF = 2'h1;
  localparam logic [1:0] MR0_BC4 = 2'h2;
  // Latency register fields
  localparam int LAT_AL_LSB  = 0;
  localparam int LAT_CWL_LSB = 8;
  localparam int LAT_TWR_LSB = 16;
  // Control register bits
  localparam int CTL_MASK = 0;
  localparam int CTL_INV  = 1;
  localparam int CTL_CRC  = 2;
  localparam int CTL_PRE2 = 3;
  // Status register bits
  localparam int ST_CRC_PERS = 0;
  localparam int ST_CRC_NONP = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_ACTIVE   = 4;
  localparam int ST_CMD_OVF  = 5;
  localparam int ST_REC_BUSY = 6;
  localparam int ST_CWL_ERR  = 7;
  localparam int ST_SPC_ERR  = 8;
  localparam int ST_BANK_LSB = 16;
  // Reset values
  localparam logic [1:0] MR0_RST = 2'h0;
  localparam logic [4:0] AL_RST  = 5'h00;
  localparam logic [4:0] CWL_RST = 5'h09;
  localparam logic [5:0] TWR_RST = 6'h0C;
  localparam logic [3:0] CTL_RST = 4'h0;
  // Timing counts in link clocks, last beat indices in strobe edges
  localparam logic [4:0] CWL_LOWEST   = 5'h09;
  localparam logic [7:0] GAP_FORBID   = 8'h05;
  localparam logic [2:0] LAST_BEAT_8  = 3'h7;
  localparam logic [2:0] LAST_BEAT_4  = 3'h3;
  typedef struct packed {
    logic [7:0] start;
    logic [3:0] bank;
    logic       col_hi;
    logic       chop;
    logic       ap;
  } sdwb_cmd_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sdwb_beat_t;
endpackage

// ### rtl/sdwb_core.sv
// Write burst capture, masking and auto-precharge logic of the memory device
// Behaviour
// R1: Bursts: fixed eight, fixed chop four, per-command
// R2: Per-command mode: address twelve low chops
// R3: Mode bits 00 eight, 01 per-command
// R4: Mode bits 10 always chop four
// R5: Address ten low keeps bank open
// R6: Address ten high precharges after burst
// R7: Masking only byte wide, shared pin
// R8: Masking and inversion never both active
// R9: Mask pin low discards that lane
// R10: Mask pin high stores that lane
// R11: CRC mode follows mask enable setting
// R12: Write latency is additive plus column
// R13: Two-clock preamble forbids lowest column latency
// R14: Two-clock preamble forbids five-clock spacing
// R15: Back-to-back writes four clocks apart accepted
// R16: Recovery measured from edge after data
// R17: Controller spaces write to precharge
// R18: Data on both strobe edges, chop stores four
// R19: Controller drives preamble and postamble
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module sdwb_core (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Link pins from the memory controller
  input  wire logic              link_ck,
  input  wire logic              cmd_write_n,
  input  wire logic              cmd_activate_n,
  input  wire logic [3:0]        bank_addr,
  input  wire logic [12:0]       addr,
  input  wire logic              data_strobe,
  input  wire logic [7:0]        dq,
  input  wire logic              write_mask_n,
  // Stored beats towards the core
  output logic                   beat_valid,
  input  wire logic              beat_ready,
  output sdwb_pkg::sdwb_beat_t   beat_data,
  // Recovery reference edge
  output logic                   write_ref_pulse
);
  function automatic logic burst_chop(input logic [1:0] mr, input logic a12);
    return (mr == sdwb_pkg::MR0_BC4) || ((mr == sdwb_pkg::MR0_OTF) && !a12);
  endfunction

  logic [29:0]          sync1_q;
  logic [29:0]          sync2_q;
  logic [1:0]           prev_q;
  logic                 s_ck;
  logic                 s_dqs;
  logic                 s_wr_n;
  logic                 s_act_n;
  logic [3:0]           s_ba;
  logic [12:0]          s_addr;
  logic [7:0]           s_dq;
  logic                 s_mask_n;
  logic                 ck_rise;
  logic                 dqs_edge;
  logic [1:0]           mr0_q;
  logic [4:0]           al_q;
  logic [4:0]           cwl_q;
  logic [5:0]           twr_q;
  logic [3:0]           ctrl_q;
  logic                 overrun_q;
  logic                 cmd_ovf_q;
  logic                 spc_err_q;
  logic [15:0]          wcount_q;
  logic [7:0]           peek_q;
  logic [31:0]          rd_mux;
  logic [7:0]           ck_cnt_q;
  logic [7:0]           gap_q;
  sdwb_pkg::sdwb_cmd_t  cq_q [4];
  logic [1:0]           cq_wp_q;
  logic [1:0]           cq_rp_q;
  logic [2:0]           cq_n_q;
  sdwb_pkg::sdwb_cmd_t  head;
  sdwb_pkg::sdwb_cmd_t  cur_q;
  sdwb_pkg::sdwb_cmd_t  cur;
  logic                 cmd_req;
  logic                 cmd_take;
  logic                 take_chop;
  logic [7:0]           take_start;
  logic                 open_now;
  logic                 act_q;
  logic [2:0]           beat_idx_q;
  logic [2:0]           idx;
  logic                 beat_now;
  logic                 done_now;
  logic                 mask_on;
  logic                 inv_on;
  logic                 keep;
  logic                 push;
  logic                 await_ref_q;
  logic                 ap_pend_q;
  logic [3:0]           ap_bank_q;
  logic                 rec_busy_q;
  logic [5:0]           rec_cnt_q;
  logic [3:0]           rec_bank_q;
  logic                 rec_end;
  logic [15:0]          bank_open_q;
  sdwb_pkg::sdwb_beat_t fb_q [2];
  logic                 fw_q;
  logic                 fr_q;
  logic [1:0]           fn_q;
  logic                 fifo_rdy;
  logic                 pop;
  logic [7:0]           mem_q [256];

  // Two-stage synchroniser for every link pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // Active-low pins start at their idle level, so no false command after reset
      sync1_q <= 30'h0C00_0001;
      sync2_q <= 30'h0C00_0001;
      prev_q  <= 2'h0;
    end else begin
      sync1_q <= {link_ck, data_strobe, cmd_write_n, cmd_activate_n, bank_addr, addr, dq,
                  write_mask_n};
      sync2_q <= sync1_q;
      prev_q  <= {s_ck, s_dqs};
    end
  end
  assign {s_ck, s_dqs, s_wr_n, s_act_n, s_ba, s_addr, s_dq, s_mask_n} = sync2_q;
  assign ck_rise  = s_ck && !prev_q[1];
  // R18 both strobe edges
  assign dqs_edge = s_dqs ^ prev_q[0];

  // Pin sharing: inversion takes the pin, masking only without it
  // R7 shared mask pin
  assign inv_on  = ctrl_q[sdwb_pkg::CTL_INV];
  // R8 exclusive functions
  assign mask_on = ctrl_q[sdwb_pkg::CTL_MASK] && !inv_on;

  // Command decode on link clock rising edges
  assign cmd_req    = ck_rise && !s_wr_n;
  assign cmd_take   = cmd_req && (cq_n_q != 3'h4);
  // R1 three burst options
  assign take_chop  = burst_chop(mr0_q, s_addr[12]);
  // R12 latency sum
  assign take_start = ck_cnt_q + 8'(al_q) + 8'(cwl_q);
  assign head       = cq_q[cq_rp_q];
  assign open_now   = ck_rise && (cq_n_q != 3'h0) && (ck_cnt_q == head.start);
  assign cur        = open_now ? head : cur_q;
  assign idx        = open_now ? 3'h0 : beat_idx_q;
  // R15 each command opens its own window
  assign beat_now   = dqs_edge && (act_q || open_now);
  assign done_now   = beat_now &&
                      (idx == (cur.chop ? sdwb_pkg::LAST_BEAT_4 : sdwb_pkg::LAST_BEAT_8));
  // R9 low pin discards
  assign keep       = !(mask_on && !s_mask_n);
  assign push       = beat_now && keep && fifo_rdy;
  assign rec_end    = rec_busy_q && ck_rise && (rec_cnt_q == 6'h01);

  // Link clock counter and spacing watch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ck_cnt_q  <= 8'h00;
      gap_q     <= 8'hFF;
      spc_err_q <= 1'b0;
    end else begin
      if (ck_rise) begin
        ck_cnt_q <= ck_cnt_q + 8'h01;
        if (cmd_req) begin
          gap_q <= 8'h01;
        end else if (gap_q != 8'hFF) begin
          gap_q <= gap_q + 8'h01;
        end
      end
      // R14 forbidden spacing flagged
      if (cmd_req && ctrl_q[sdwb_pkg::CTL_PRE2] && gap_q == sdwb_pkg::GAP_FORBID) begin
        spc_err_q <= 1'b1;
      end else if (reg_wr && reg_addr == sdwb_pkg::REG_STAT &&
                   reg_wdata[sdwb_pkg::ST_SPC_ERR]) begin
        spc_err_q <= 1'b0;
      end
    end
  end

  // Pending write commands
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cq_wp_q <= 2'h0;
      cq_rp_q <= 2'h0;
      cq_n_q  <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        cq_q[i] <= '0;
      end
    end else begin
      if (cmd_take) begin
        // R2 per-command chop
        // R5 address ten decides precharge
        cq_q[cq_wp_q] <= '{start: take_start, bank: s_ba, col_hi: s_addr[3],
                           chop: take_chop, ap: s_addr[10]};
        cq_wp_q <= cq_wp_q + 2'h1;
      end
      if (open_now) begin
        cq_rp_q <= cq_rp_q + 2'h1;
      end
      cq_n_q <= cq_n_q + {2'h0, cmd_take} - {2'h0, open_now};
    end
  end

  // Burst beat counting
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      act_q      <= 1'b0;
      beat_idx_q <= 3'h0;
      cur_q      <= '0;
    end else begin
      if (open_now) begin
        cur_q <= head;
      end
      if (done_now) begin
        act_q      <= 1'b0;
        beat_idx_q <= 3'h0;
      end else if (beat_now) begin
        act_q      <= 1'b1;
        beat_idx_q <= idx + 3'h1;
      end else if (open_now) begin
        act_q      <= 1'b1;
        beat_idx_q <= 3'h0;
      end
    end
  end

  // Recovery reference edge and auto-precharge timer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      await_ref_q     <= 1'b0;
      ap_pend_q       <= 1'b0;
      ap_bank_q       <= 4'h0;
      write_ref_pulse <= 1'b0;
      rec_busy_q      <= 1'b0;
      rec_cnt_q       <= 6'h00;
      rec_bank_q      <= 4'h0;
    end else begin
      write_ref_pulse <= 1'b0;
      if (done_now) begin
        await_ref_q <= 1'b1;
        ap_pend_q   <= cur.ap;
        ap_bank_q   <= cur.bank;
      end else if (await_ref_q && ck_rise) begin
        // R16 reference edge
        await_ref_q     <= 1'b0;
        ap_pend_q       <= 1'b0;
        write_ref_pulse <= 1'b1;
        if (ap_pend_q) begin
          rec_busy_q <= 1'b1;
          rec_bank_q <= ap_bank_q;
          rec_cnt_q  <= (twr_q == 6'h00) ? 6'h01 : twr_q;
        end
      end
      if (rec_end) begin
        rec_busy_q <= 1'b0;
      end else if (rec_busy_q && ck_rise) begin
        rec_cnt_q <= rec_cnt_q - 6'h01;
      end
    end
  end

  // Open bank tracking, precharge wins over activate
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bank_open_q <= 16'h0000;
    end else begin
      if (ck_rise && !s_act_n) begin
        bank_open_q[s_ba] <= 1'b1;
      end
      // R6 auto precharge closes bank
      if (rec_end) begin
        bank_open_q[rec_bank_q] <= 1'b0;
      end
    end
  end

  // Two-entry beat buffer
  assign fifo_rdy   = (fn_q != 2'h2);
  assign beat_valid = (fn_q != 2'h0);
  assign beat_data  = fb_q[fr_q];
  assign pop        = beat_valid && beat_ready;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fw_q  <= 1'b0;
      fr_q  <= 1'b0;
      fn_q  <= 2'h0;
      fb_q[0] <= '0;
      fb_q[1] <= '0;
    end else begin
      if (push) begin
        // R10 high pin stores, inversion restored
        fb_q[fw_q] <= '{addr: {cur.bank, cur.col_hi, idx},
                        data: (inv_on && !s_mask_n) ? ~s_dq : s_dq};
        fw_q <= !fw_q;
      end
      if (pop) begin
        fr_q <= !fr_q;
      end
      fn_q <= fn_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Array write as beats drain
  always_ff @(posedge ref_clk) begin
    if (pop) begin
      mem_q[beat_data.addr] <= beat_data.data;
    end
  end

  // Register writes and sticky flags, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mr0_q     <= sdwb_pkg::MR0_RST;
      al_q      <= sdwb_pkg::AL_RST;
      cwl_q     <= sdwb_pkg::CWL_RST;
      twr_q     <= sdwb_pkg::TWR_RST;
      ctrl_q    <= sdwb_pkg::CTL_RST;
      peek_q    <= 8'h00;
      overrun_q <= 1'b0;
      cmd_ovf_q <= 1'b0;
      wcount_q  <= 16'h0000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          // R3 burst mode select
          sdwb_pkg::REG_MODE0: mr0_q <= reg_wdata[1:0];
          sdwb_pkg::REG_LAT: begin
            al_q  <= reg_wdata[sdwb_pkg::LAT_AL_LSB +: 5];
            cwl_q <= reg_wdata[sdwb_pkg::LAT_CWL_LSB +: 5];
            twr_q <= reg_wdata[sdwb_pkg::LAT_TWR_LSB +: 6];
          end
          sdwb_pkg::REG_CTRL:  ctrl_q <= reg_wdata[3:0];
          sdwb_pkg::REG_PEEKA: peek_q <= reg_wdata[7:0];
          sdwb_pkg::REG_STAT: begin
            if (reg_wdata[sdwb_pkg::ST_OVERRUN]) overrun_q <= 1'b0;
            if (reg_wdata[sdwb_pkg::ST_CMD_OVF]) cmd_ovf_q <= 1'b0;
          end
          default: ;
        endcase
      end
      if (beat_now && keep && !fifo_rdy) overrun_q <= 1'b1;
      if (cmd_req && !cmd_take) cmd_ovf_q <= 1'b1;
      if (pop) wcount_q <= wcount_q + 16'h0001;
    end
  end

  // Register read mux, data one cycle after the strobe
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      sdwb_pkg::REG_MODE0: rd_mux[1:0] = mr0_q;
      sdwb_pkg::REG_LAT: begin
        rd_mux[sdwb_pkg::LAT_AL_LSB +: 5]  = al_q;
        rd_mux[sdwb_pkg::LAT_CWL_LSB +: 5] = cwl_q;
        rd_mux[sdwb_pkg::LAT_TWR_LSB +: 6] = twr_q;
      end
      sdwb_pkg::REG_CTRL: rd_mux[3:0] = ctrl_q;
      sdwb_pkg::REG_STAT: begin
        // R11 CRC mode from mask enable
        rd_mux[sdwb_pkg::ST_CRC_PERS] = ctrl_q[sdwb_pkg::CTL_CRC] && ctrl_q[sdwb_pkg::CTL_MASK];
        rd_mux[sdwb_pkg::ST_CRC_NONP] = ctrl_q[sdwb_pkg::CTL_CRC] && !ctrl_q[sdwb_pkg::CTL_MASK];
        rd_mux[sdwb_pkg::ST_CONFLICT] = ctrl_q[sdwb_pkg::CTL_MASK] && inv_on;
        rd_mux[sdwb_pkg::ST_OVERRUN]  = overrun_q;
        rd_mux[sdwb_pkg::ST_ACTIVE]   = act_q;
        rd_mux[sdwb_pkg::ST_CMD_OVF]  = cmd_ovf_q;
        rd_mux[sdwb_pkg::ST_REC_BUSY] = rec_busy_q;
        // R13 lowest latency with long preamble
        rd_mux[sdwb_pkg::ST_CWL_ERR]  = ctrl_q[sdwb_pkg::CTL_PRE2] &&
                                        (cwl_q == sdwb_pkg::CWL_LOWEST);
        rd_mux[sdwb_pkg::ST_SPC_ERR]  = spc_err_q;
        rd_mux[sdwb_pkg::ST_BANK_LSB +: 16] = bank_open_q;
      end
      sdwb_pkg::REG_COUNT: rd_mux[15:0] = wcount_q;
      sdwb_pkg::REG_PEEKA: rd_mux[7:0]  = peek_q;
      sdwb_pkg::REG_PEEKD: rd_mux[7:0]  = mem_q[peek_q];
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_take;
    cmd_take;
  endsequence
  sequence s_ref_edge;
    await_ref_q && ck_rise && !done_now;
  endsequence

  property p_fixed_eight;
    (cmd_take && mr0_q == sdwb_pkg::MR0_BL8) |-> !take_chop;
  endproperty
  a_fixed_eight: assert property (p_fixed_eight) // R3
    else $error("Fixed eight-beat mode chose a chop");
  property p_otf;
    (cmd_take && mr0_q == sdwb_pkg::MR0_OTF) |-> (take_chop == !s_addr[12]);
  endproperty
  a_otf: assert property (p_otf) // R2
    else $error("Per-command burst choice ignores address twelve");
  property p_fixed_chop;
    (cmd_take && mr0_q == sdwb_pkg::MR0_BC4) |-> take_chop;
  endproperty
  a_fixed_chop: assert property (p_fixed_chop) // R4
    else $error("Fixed chop mode made an eight-beat burst");
  property p_latency;
    s_take |=> (cq_q[$past(cq_wp_q)].start == $past(ck_cnt_q) + 8'(al_q) + 8'(cwl_q));
  endproperty
  a_latency: assert property (p_latency) // R12
    else $error("Data window not at additive plus column latency");
  property p_mask_drop;
    (beat_now && mask_on && !s_mask_n) |-> !push ##1 (fn_q <= $past(fn_q));
  endproperty
  a_mask_drop: assert property (p_mask_drop) // R9
    else $error("Masked lane was stored");
  property p_mask_keep;
    (beat_now && mask_on && s_mask_n && fifo_rdy) |-> push;
  endproperty
  a_mask_keep: assert property (p_mask_keep) // R10
    else $error("Unmasked lane was dropped");
  property p_exclusive;
    (beat_now && inv_on && fifo_rdy) |-> push;
  endproperty
  a_exclusive: assert property (p_exclusive) // R8
    else $error("Beat dropped by masking while inversion owns the pin");
  property p_ref_edge;
    s_ref_edge |=> write_ref_pulse ##1 !write_ref_pulse;
  endproperty
  a_ref_edge: assert property (p_ref_edge) // R16
    else $error("Reference edge after last beat missing");
  property p_chop_end;
    (act_q && !open_now && cur_q.chop && beat_idx_q == 3'h3 && dqs_edge) |=> !act_q;
  endproperty
  a_chop_end: assert property (p_chop_end) // R18
    else $error("Chopped burst stored more than four beats");
  property p_autopre;
    rec_end |=> !bank_open_q[$past(rec_bank_q)];
  endproperty
  a_autopre: assert property (p_autopre) // R6
    else $error("Auto precharge left the bank open");
  property p_plain;
    (done_now && !cur.ap) |=> !ap_pend_q;
  endproperty
  a_plain: assert property (p_plain) // R5
    else $error("Plain write scheduled a precharge");
endmodule

// ### tb/sdwb_ctrl_model.sv
// Memory controller model driving the write link pins
`timescale 1ns/1ps
module sdwb_ctrl_model (
  // Link pins towards the device
  output logic        link_ck,
  output logic        cmd_write_n,
  output logic        cmd_activate_n,
  output logic [3:0]  bank_addr,
  output logic [12:0] addr,
  output logic        data_strobe,
  output logic [7:0]  dq,
  output logic        write_mask_n
);
  realtime last_edge_t = 0.0;
  initial begin
    link_ck        = 1'b0;
    cmd_write_n    = 1'b1;
    cmd_activate_n = 1'b1;
    bank_addr      = 4'h0;
    addr           = 13'h0000;
    data_strobe    = 1'b0;
    dq             = 8'h00;
    write_mask_n   = 1'b1;
  end
  // Free running link clock, 160 ns period
  always #80 link_ck = ~link_ck;
  // no precharge command is issued; banks close only by auto precharge
  // command fields held across the sampling rise
  task automatic issue(input int gap, input logic act, input logic [3:0] b,
                       input logic [12:0] a);
    repeat (gap) @(negedge link_ck);
    cmd_write_n    = act;
    cmd_activate_n = ~act;
    bank_addr      = b;
    addr           = a;
    @(negedge link_ck);
    cmd_write_n    = 1'b1;
    cmd_activate_n = 1'b1;
    bank_addr      = ~b;
    addr           = ~a;
  endtask
  // strobe low as preamble, one beat per edge, low after
  task automatic burst(input int wl, input int n, input logic [7:0] base,
                       input logic [7:0] keep);
    #(wl * 160 - 120);
    for (int i = 0; i < n; i++) begin
      dq           = base + 8'(i);
      write_mask_n = keep[i];
      #40;
      data_strobe  = ~data_strobe;
      last_edge_t  = $realtime;
      #20;
      // Released lanes show the inverse, clear of a following burst's setup
      dq           = ~dq;
      write_mask_n = ~write_mask_n;
      #20;
    end
  endtask
  task automatic wr(input int gap, input logic [3:0] b, input logic [12:0] a,
                    input int wl, input int n, input logic [7:0] base, input logic [7:0] keep);
    issue(gap, 1'b0, b, a);
    fork
      burst(wl, n, base, keep);
    join_none
  endtask
endmodule

// ### tb/sdwb_core_tb.sv
// Self-checking bench for the write burst block
`timescale 1ns/1ps
module sdwb_core_tb;
  logic                 ref_clk = 1'b0;
  logic                 reset = 1'b1;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0000_0000;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  logic                 link_ck, cmd_write_n, cmd_activate_n, data_strobe, write_mask_n;
  logic [3:0]           bank_addr;
  logic [12:0]          addr;
  logic [7:0]           dq;
  logic                 beat_valid;
  logic                 beat_ready = 1'b1;
  sdwb_pkg::sdwb_beat_t beat_data;
  logic                 write_ref_pulse;
  int                   err_count = 0;
  int                   check_count = 0;
  int                   ref_n = 0;
  realtime              ref_t = 0.0;
  sdwb_pkg::sdwb_beat_t got_q[$];
  sdwb_pkg::sdwb_beat_t exp_q[$];

  sdwb_core DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_ck(link_ck), .cmd_write_n(cmd_write_n), .cmd_activate_n(cmd_activate_n),
    .bank_addr(bank_addr), .addr(addr), .data_strobe(data_strobe), .dq(dq),
    .write_mask_n(write_mask_n), .beat_valid(beat_valid), .beat_ready(beat_ready),
    .beat_data(beat_data), .write_ref_pulse(write_ref_pulse));
  sdwb_ctrl_model u_ctl (.link_ck(link_ck), .cmd_write_n(cmd_write_n),
    .cmd_activate_n(cmd_activate_n), .bank_addr(bank_addr), .addr(addr),
    .data_strobe(data_strobe), .dq(dq), .write_mask_n(write_mask_n));

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (beat_valid === 1'b1 && beat_ready === 1'b1)
      got_q.push_back(beat_data);
    if (write_ref_pulse === 1'b1) begin
      ref_n++;
      ref_t = $realtime;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    logic [31:0] d;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    chk(what, exp, d & m);
  endtask
  task automatic expb(input logic [3:0] b, input logic ch, input logic [7:0] base,
                      input int n, input logic [7:0] keep);
    for (int i = 0; i < n; i++)
      if (keep[i])
        exp_q.push_back(sdwb_pkg::sdwb_beat_t'({b, ch, 3'(i), base + 8'(i)}));
  endtask
  task automatic wait_ref(input int n);
    for (int w = 0; w < 5000 && ref_n < n; w++)
      @(posedge ref_clk);
  endtask
  task automatic drain(input int pulses, input logic tchk);
    real dt;
    wait_ref(pulses);
    repeat (20) @(posedge ref_clk);
    dt = ref_t - u_ctl.last_edge_t;
    if (tchk)
      chk("ref pulse delay", 32'h1, 32'(dt > 80.0 && dt <= 180.0));
    chk("beat count", 32'(exp_q.size()), 32'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      chk("beat", 32'(exp_q.pop_front()), 32'(got_q.pop_front()));
    exp_q.delete();
    got_q.delete();
    ref_n = 0;
  endtask

  task automatic t_regs();
    rchk("mode zero", sdwb_pkg::REG_MODE0, 32'h0000_0003, 32'h0000_0000);
    rchk("latency", sdwb_pkg::REG_LAT, 32'h003F_1F1F, 32'h000C_0900);
    rchk("status", sdwb_pkg::REG_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    rw(8'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_bursts();
    u_ctl.wr(1, 4'h5, 13'h0008, 9, 8, 8'h20, 8'hFF);
    expb(4'h5, 1'b1, 8'h20, 8, 8'hFF);
    drain(1, 1'b1);
    rw(sdwb_pkg::REG_MODE0, 32'(sdwb_pkg::MR0_OTF));
    u_ctl.wr(1, 4'h1, 13'h0000, 9, 4, 8'h30, 8'hFF);
    u_ctl.wr(3, 4'h6, 13'h1000, 9, 8, 8'h40, 8'hFF);
    expb(4'h1, 1'b0, 8'h30, 4, 8'hFF);
    expb(4'h6, 1'b0, 8'h40, 8, 8'hFF);
    drain(2, 1'b1);
    rw(sdwb_pkg::REG_MODE0, 32'(sdwb_pkg::MR0_BC4));
    u_ctl.wr(1, 4'h7, 13'h1000, 9, 8, 8'h50, 8'hFF);
    expb(4'h7, 1'b0, 8'h50, 4, 8'hFF);
    drain(1, 1'b0);
    rw(sdwb_pkg::REG_MODE0, 32'(sdwb_pkg::MR0_BL8));
    rw(sdwb_pkg::REG_LAT, 32'h000C_090A);
    u_ctl.wr(1, 4'h8, 13'h0000, 19, 8, 8'h70, 8'hFF);
    expb(4'h8, 1'b0, 8'h70, 8, 8'hFF);
    drain(1, 1'b1);
    rw(sdwb_pkg::REG_LAT, 32'h000C_0900);
    $display("test bursts done");
  endtask
  task automatic t_mask();
    logic [7:0] keep;
    keep = 8'hA5;
    u_ctl.wr(1, 4'h2, 13'h0000, 9, 8, 8'h60, 8'hFF);
    expb(4'h2, 1'b0, 8'h60, 8, 8'hFF);
    drain(1, 1'b1);
    rw(sdwb_pkg::REG_CTRL, 32'h0000_0001);
    u_ctl.wr(1, 4'h2, 13'h0000, 9, 8, 8'hA0, keep);
    expb(4'h2, 1'b0, 8'hA0, 8, keep);
    drain(1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rw(sdwb_pkg::REG_PEEKA, 32'({4'h2, 1'b0, 3'(i)}));
      rchk("array byte", sdwb_pkg::REG_PEEKD, 32'h0000_00FF,
           32'(keep[i] ? 8'hA0 + 8'(i) : 8'h60 + 8'(i)));
    end
    rw(sdwb_pkg::REG_CTRL, 32'h0000_0003);
    u_ctl.wr(1, 4'h2, 13'h0000, 9, 8, 8'hB0, keep);
    for (int i = 0; i < 8; i++)
      exp_q.push_back(sdwb_pkg::sdwb_beat_t'({4'h2, 1'b0, 3'(i),
                      keep[i] ? 8'hB0 + 8'(i) : ~(8'hB0 + 8'(i))}));
    drain(1, 1'b1);
    rw(sdwb_pkg::REG_CTRL, 32'h0000_0000);
    rchk("stored count", sdwb_pkg::REG_COUNT, 32'h0000_FFFF, 32'h0000_0034);
    $display("test mask done");
  endtask
  task automatic t_modes();
    logic [3:0] cv [4];
    logic [2:0] sv [4];
    cv = '{4'h3, 4'h5, 4'h4, 4'h1};
    sv = '{3'h4, 3'h1, 3'h2, 3'h0};
    for (int i = 0; i < 4; i++) begin
      rw(sdwb_pkg::REG_CTRL, 32'(cv[i]));
      rchk("mode status", sdwb_pkg::REG_STAT, 32'h0000_0007, 32'(sv[i]));
    end
    rw(sdwb_pkg::REG_CTRL, 32'h0000_0008);
    rchk("cwl check", sdwb_pkg::REG_STAT, 32'h0000_0080, 32'h0000_0080);
    rw(sdwb_pkg::REG_LAT, 32'h000C_0A00);
    rchk("cwl check", sdwb_pkg::REG_STAT, 32'h0000_0080, 32'h0000_0000);
    u_ctl.wr(1, 4'h9, 13'h0000, 10, 8, 8'h80, 8'hFF);
    u_ctl.wr(4, 4'hA, 13'h0000, 10, 8, 8'h90, 8'hFF);
    expb(4'h9, 1'b0, 8'h80, 8, 8'hFF);
    expb(4'hA, 1'b0, 8'h90, 8, 8'hFF);
    drain(2, 1'b1);
    rchk("spacing", sdwb_pkg::REG_STAT, 32'h0000_0100, 32'h0000_0100);
    rw(sdwb_pkg::REG_STAT, 32'h0000_0100);
    rchk("spacing", sdwb_pkg::REG_STAT, 32'h0000_0100, 32'h0000_0000);
    rw(sdwb_pkg::REG_CTRL, 32'h0000_0000);
    rw(sdwb_pkg::REG_LAT, 32'h000C_0900);
    $display("test modes done");
  endtask
  task automatic t_ovf();
    beat_ready <= 1'b0;
    u_ctl.wr(1, 4'hB, 13'h0000, 9, 8, 8'hC0, 8'hFF);
    wait_ref(1);
    beat_ready <= 1'b1;
    expb(4'hB, 1'b0, 8'hC0, 2, 8'hFF);
    drain(1, 1'b1);
    rchk("overrun", sdwb_pkg::REG_STAT, 32'h0000_0008, 32'h0000_0008);
    rw(sdwb_pkg::REG_STAT, 32'h0000_0008);
    rchk("overrun", sdwb_pkg::REG_STAT, 32'h0000_0008, 32'h0000_0000);
    $display("test overrun done");
  endtask
  task automatic t_ap();
    u_ctl.issue(1, 1'b1, 4'h3, 13'h0000);
    u_ctl.issue(1, 1'b1, 4'h4, 13'h0000);
    u_ctl.wr(1, 4'h4, 13'h0000, 9, 8, 8'hD0, 8'hFF);
    u_ctl.wr(3, 4'h3, 13'h0400, 9, 8, 8'hE0, 8'hFF);
    expb(4'h4, 1'b0, 8'hD0, 8, 8'hFF);
    expb(4'h3, 1'b0, 8'hE0, 8, 8'hFF);
    drain(2, 1'b1);
    repeat (64) @(posedge ref_clk);
    rchk("open banks", sdwb_pkg::REG_STAT, 32'h0018_0040, 32'h0018_0040);
    repeat (32) @(posedge ref_clk);
    rchk("open banks", sdwb_pkg::REG_STAT, 32'h0018_0040, 32'h0010_0000);
    $display("test precharge done");
  endtask

  initial begin
    #400_000;
    err_count++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_bursts();
    t_mask();
    t_modes();
    t_ovf();
    t_ap();
    end_sim();
  end
endmodule
